// [hw/pwo_channel.sv]
`timescale 1ns/1ps
// Behaviour
// - 16-bit timer clocked from selected source
// - Standard: rise at phase, fall at duty
// - Standard: restart after period, period+1 ticks
// - Set mode: raise output at phase match
// - Set mode: high until software clear/disable
// - Set mode: level write lands next tick unless phase matches
// - Toggle mode: invert output at phase match
// - Toggle mode: level writes have no effect
// - Center: count up to period, down to 0
// - Center: duty rises counting up, falls down
// - Center: 2*(period+1) ticks, writes ignored
// - Invert bit inverts the pin
// - Level read is resynchronised, lags output
// - Independent: run while enabled, ignore peers
// - Sync start: hold until peer trigger
// - One-shot: start on edge, stop at period in edge modes
// - Continuous: later edges reset timer to 1
// - Four flags set on match rising edges
// - Direction bit picks center offset match slope
// - Reload at period boundary when armed; clears arm
module pwo_channel #(
	parameter int NPEER = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] clk_src_tick,
	input wire logic [NPEER-1:0] peer_sync_trigger,
	output logic pwm_pin,
	output logic pwm_pin_oe_n,
	output logic offset_match
);
	// Bus state
	logic [31:0] hrdata_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	// Configuration and compare values
	pwo_pkg::pwo_cfg_t cfg_ff;
	pwo_pkg::pwo_vals_t buf_ff;
	pwo_pkg::pwo_vals_t act_ff;
	logic load_arm_bit_ff;
	logic sw_pend_ff;
	logic sw_val_ff;
	// Timer core
	pwo_pkg::pwo_state_t state_ff;
	pwo_pkg::pwo_state_t nxt_state;
	logic [15:0] channel_timer_ff;
	logic [15:0] nxt_timer;
	logic dir_up_ff;
	logic nxt_dir_up;
	logic out_ff;
	logic nxt_out;
	logic [6:0] pre_cnt_ff;
	// Flags and edge history
	logic [3:0] flags_ff;
	logic [3:0] hit_prev_ff;
	// Synchronisers
	logic [1:0] src_s1_ff;
	logic [1:0] src_s2_ff;
	logic [1:0] src_s3_ff;
	logic [NPEER-1:0] peer_s1_ff;
	logic [NPEER-1:0] peer_s2_ff;
	logic [NPEER-1:0] peer_s3_ff;
	logic lvl_s1_ff;
	logic pin_level_bit_ff;
	// Output flops
	logic pwm_pin_ff;
	logic pwm_pin_oe_n_ff;
	logic offset_match_ff;

	// Address phase decode
	wire addr_take = hsel & hready & htrans[1];
	wire wr_take = addr_take & hwrite;
	wire rd_take = addr_take & ~hwrite;
	wire [7:0] a_lo = haddr[7:0];
	wire in_map = (haddr[31:8] == 24'h000000);
	// Data phase write strobes
	wire wr_ctrl = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_CTRL);
	wire wr_clk = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_CLKCON);
	wire wr_ofs = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_OFSCON);
	wire wr_load = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_LOAD);
	wire wr_ph = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_PHASE);
	wire wr_dc = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_DUTY);
	wire wr_pr = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_PERIOD);
	wire wr_of = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_OFFSET);
	wire wr_flags = wr_pend_ff & (wr_addr_ff == pwo_pkg::ADDR_FLAGS);
	wire arm_set = wr_load & hwdata[pwo_pkg::LOAD_ARM_BIT];

	// Register views for reading
	wire [31:0] ctrl_view = {24'h000000, cfg_ff.channel_on_bit, cfg_ff.oe, pin_level_bit_ff,
		cfg_ff.invert_level_bit, cfg_ff.waveform_mode_field, 2'b00};
	wire [31:0] clk_view = {25'h0000000, cfg_ff.prescale, 2'b00, cfg_ff.clock_source};
	wire [31:0] ofs_view = {27'h0000000, cfg_ff.center_match_direction_bit,
		cfg_ff.sync_source_select, cfg_ff.offset_mode_field};
	// Read mux; unmapped addresses read zero
	wire [31:0] rd_data = !in_map ? 32'h00000000 :
		(a_lo == pwo_pkg::ADDR_CTRL) ? ctrl_view :
		(a_lo == pwo_pkg::ADDR_CLKCON) ? clk_view :
		(a_lo == pwo_pkg::ADDR_OFSCON) ? ofs_view :
		(a_lo == pwo_pkg::ADDR_LOAD) ? {31'h00000000, load_arm_bit_ff} :
		(a_lo == pwo_pkg::ADDR_PHASE) ? {16'h0000, buf_ff.phase_value} :
		(a_lo == pwo_pkg::ADDR_DUTY) ? {16'h0000, buf_ff.duty_cycle_value} :
		(a_lo == pwo_pkg::ADDR_PERIOD) ? {16'h0000, buf_ff.period_value} :
		(a_lo == pwo_pkg::ADDR_OFFSET) ? {16'h0000, buf_ff.offset_value} :
		(a_lo == pwo_pkg::ADDR_TIMER) ? {16'h0000, channel_timer_ff} :
		(a_lo == pwo_pkg::ADDR_FLAGS) ? {28'h0000000, flags_ff} : 32'h00000000;

	// Clock source select and prescaler
	wire [1:0] src_rise = src_s2_ff & ~src_s3_ff;
	wire src_pulse = (cfg_ff.clock_source == 2'b00) ? 1'b1 :
		(cfg_ff.clock_source == 2'b01) ? src_rise[0] :
		(cfg_ff.clock_source == 2'b10) ? src_rise[1] : 1'b0;
	wire [7:0] pre_shift = 8'h01 << cfg_ff.prescale;
	wire [6:0] pre_limit = 7'(pre_shift - 8'h01);
	// At or above the limit, so a smaller prescale written mid-count never waits for a wrap
	wire tick = ce & src_pulse & (pre_cnt_ff >= pre_limit);

	// Peer trigger select and edge
	wire peer_lvl = peer_s2_ff[cfg_ff.sync_source_select];
	wire peer_old = peer_s3_ff[cfg_ff.sync_source_select];
	wire peer_rise = ce & peer_lvl & ~peer_old;

	// Compare hits against the active values
	wire running = (state_ff == pwo_pkg::ST_RUN);
	wire is_center = (cfg_ff.waveform_mode_field == pwo_pkg::WM_CENTER);
	wire ph_eq = (channel_timer_ff == act_ff.phase_value);
	wire dc_eq = (channel_timer_ff == act_ff.duty_cycle_value);
	wire pr_eq = (channel_timer_ff == act_ff.period_value);
	wire of_eq = (channel_timer_ff == act_ff.offset_value);
	// Offset match slope only matters in center mode
	wire of_slope = !is_center | (dir_up_ff != cfg_ff.center_match_direction_bit);
	wire [3:0] hits = {running & of_eq & of_slope, running & ph_eq,
		running & dc_eq, running & pr_eq};
	wire tick_run = tick & running;
	// Period boundary: wrap in edge modes, bottom turn in center mode
	wire bound = tick_run & (is_center ? (!dir_up_ff & channel_timer_ff == 16'h0000) : pr_eq);
	wire do_load = ce & load_arm_bit_ff & (bound | !cfg_ff.channel_on_bit);

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
		end else begin
			wr_pend_ff <= wr_take & in_map;
			wr_addr_ff <= a_lo;
			if (rd_take) begin
				hrdata_ff <= rd_data;
			end
		end
	end

	// Configuration writes; bus access is not frozen by the clock enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= '0;
			buf_ff <= '0;
		end else begin
			if (wr_ctrl) begin
				cfg_ff.channel_on_bit <= hwdata[pwo_pkg::CTRL_ON_BIT];
				cfg_ff.oe <= hwdata[pwo_pkg::CTRL_OE_BIT];
				cfg_ff.invert_level_bit <= hwdata[pwo_pkg::CTRL_INV_BIT];
				cfg_ff.waveform_mode_field <= pwo_pkg::pwo_wmode_t'(hwdata[pwo_pkg::CTRL_MODE_LSB +: 2]);
			end
			if (wr_clk) begin
				cfg_ff.prescale <= hwdata[pwo_pkg::CLK_PS_LSB +: 3];
				cfg_ff.clock_source <= hwdata[pwo_pkg::CLK_CS_LSB +: 2];
			end
			if (wr_ofs) begin
				cfg_ff.offset_mode_field <= pwo_pkg::pwo_omode_t'(hwdata[pwo_pkg::OFS_MODE_LSB +: 2]);
				cfg_ff.sync_source_select <= hwdata[pwo_pkg::OFS_SRC_LSB +: 2];
				cfg_ff.center_match_direction_bit <= hwdata[pwo_pkg::OFS_DIR_BIT];
			end
			// Writes go to the buffer only, never straight to the compare
			if (wr_ph) buf_ff.phase_value <= hwdata[15:0];
			if (wr_dc) buf_ff.duty_cycle_value <= hwdata[15:0];
			if (wr_pr) buf_ff.period_value <= hwdata[15:0];
			if (wr_of) buf_ff.offset_value <= hwdata[15:0];
		end
	end

	// Reload of active values; a fresh arm write wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_ff <= '0;
			load_arm_bit_ff <= 1'b0;
		end else begin
			if (do_load) begin
				act_ff <= buf_ff;
			end
			if (arm_set) begin
				load_arm_bit_ff <= 1'b1;
			end else if (do_load) begin
				load_arm_bit_ff <= 1'b0;
			end
		end
	end

	// Pending level write, only taken in set mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_pend_ff <= 1'b0;
			sw_val_ff <= 1'b0;
		end else if (wr_ctrl && cfg_ff.waveform_mode_field == pwo_pkg::WM_SET) begin
			sw_pend_ff <= 1'b1;
			sw_val_ff <= hwdata[pwo_pkg::CTRL_LEVEL_BIT];
		end else if (tick) begin
			sw_pend_ff <= 1'b0;
		end
	end

	// Timer state, count and direction
	always_comb begin
		nxt_state = state_ff;
		nxt_timer = channel_timer_ff;
		nxt_dir_up = dir_up_ff;
		if (!cfg_ff.channel_on_bit) begin
			nxt_state = pwo_pkg::ST_OFF;
			nxt_timer = pwo_pkg::VAL_RESET;
			nxt_dir_up = 1'b1;
		end else begin
			case (state_ff)
				pwo_pkg::ST_OFF: begin
					// Independent mode starts at once; others wait for a peer
					nxt_state = (cfg_ff.offset_mode_field == pwo_pkg::OM_INDEP) ?
						pwo_pkg::ST_RUN : pwo_pkg::ST_WAIT;
				end
				pwo_pkg::ST_WAIT, pwo_pkg::ST_DONE: begin
					if (peer_rise) begin
						nxt_state = pwo_pkg::ST_RUN;
					end
				end
				default: begin
					if (cfg_ff.offset_mode_field == pwo_pkg::OM_CONT && peer_rise) begin
						nxt_timer = 16'h0001;
					end else if (tick && is_center) begin
						// Each end value is held one extra tick: 2*(period+1)
						if (dir_up_ff) begin
							if (pr_eq) nxt_dir_up = 1'b0;
							else nxt_timer = channel_timer_ff + 16'h0001;
						end else begin
							if (channel_timer_ff == 16'h0000) nxt_dir_up = 1'b1;
							else nxt_timer = channel_timer_ff - 16'h0001;
						end
					end else if (tick) begin
						if (pr_eq) begin
							nxt_timer = pwo_pkg::VAL_RESET;
							if (cfg_ff.offset_mode_field == pwo_pkg::OM_ONESHOT) begin
								nxt_state = pwo_pkg::ST_DONE;
							end
						end else begin
							nxt_timer = channel_timer_ff + 16'h0001;
						end
					end
				end
			endcase
		end
	end

	// Output level per waveform mode, evaluated on channel ticks
	always_comb begin
		nxt_out = out_ff;
		if (!cfg_ff.channel_on_bit) begin
			nxt_out = 1'b0;
		end else begin
			case (cfg_ff.waveform_mode_field)
				pwo_pkg::WM_STANDARD: begin
					// Duty wins if phase and duty are equal
					if (tick_run && dc_eq) nxt_out = 1'b0;
					else if (tick_run && ph_eq) nxt_out = 1'b1;
				end
				pwo_pkg::WM_SET: begin
					if (tick_run && ph_eq) nxt_out = 1'b1;
					else if (tick && sw_pend_ff) nxt_out = sw_val_ff;
				end
				pwo_pkg::WM_TOGGLE: begin
					// Level writes never reach this branch
					if (tick_run && ph_eq) nxt_out = ~out_ff;
				end
				default: begin
					if (tick_run && dc_eq) nxt_out = dir_up_ff;
				end
			endcase
		end
	end

	// Core flops, frozen while the clock enable is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= pwo_pkg::ST_OFF;
			channel_timer_ff <= pwo_pkg::VAL_RESET;
			dir_up_ff <= 1'b1;
			out_ff <= 1'b0;
			hit_prev_ff <= 4'h0;
		end else if (ce) begin
			state_ff <= nxt_state;
			channel_timer_ff <= nxt_timer;
			dir_up_ff <= nxt_dir_up;
			out_ff <= nxt_out;
			hit_prev_ff <= hits;
		end
	end

	// Prescaler count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_ff <= pwo_pkg::PRE_RESET;
		end else if (ce && src_pulse) begin
			pre_cnt_ff <= tick ? pwo_pkg::PRE_RESET : pre_cnt_ff + 7'h01;
		end
	end

	// Match flags: set on rising edge, write one to clear, set wins
	generate
		for (genvar i = 0; i < 4; i++) begin : g_flag
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flags_ff[i] <= 1'b0;
				end else if (ce && hits[i] && !hit_prev_ff[i]) begin
					flags_ff[i] <= 1'b1;
				end else if (wr_flags && hwdata[i]) begin
					flags_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Two-flop synchronisers plus edge history; first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_s1_ff <= 2'b00;
			src_s2_ff <= 2'b00;
			src_s3_ff <= 2'b00;
			peer_s1_ff <= '0;
			peer_s2_ff <= '0;
			peer_s3_ff <= '0;
		end else if (ce) begin
			src_s1_ff <= clk_src_tick;
			src_s2_ff <= src_s1_ff;
			src_s3_ff <= src_s2_ff;
			peer_s1_ff <= peer_sync_trigger;
			peer_s2_ff <= peer_s1_ff;
			peer_s3_ff <= peer_s2_ff;
		end
	end

	// Pin drive one stage and level readback two stages behind the output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_pin_ff <= 1'b0;
			pwm_pin_oe_n_ff <= 1'b1;
			offset_match_ff <= 1'b0;
			lvl_s1_ff <= 1'b0;
			pin_level_bit_ff <= 1'b0;
		end else if (ce) begin
			pwm_pin_ff <= out_ff ^ cfg_ff.invert_level_bit;
			pwm_pin_oe_n_ff <= ~cfg_ff.oe;
			offset_match_ff <= hits[3];
			lvl_s1_ff <= out_ff;
			pin_level_bit_ff <= lvl_s1_ff;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign pwm_pin = pwm_pin_ff;
	assign pwm_pin_oe_n = pwm_pin_oe_n_ff;
	assign offset_match = offset_match_ff;

	// Checks on the channel core
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_hit_rise(int k);
		ce && hits[k] && !hit_prev_ff[k];
	endsequence

	AST_STD_RISE: assert property (
		tick_run && cfg_ff.waveform_mode_field == pwo_pkg::WM_STANDARD && ph_eq && !dc_eq &&
		cfg_ff.channel_on_bit |=> out_ff ##1 pwm_pin == !cfg_ff.invert_level_bit)
		else $error("standard mode did not rise at phase");
	AST_STD_WRAP: assert property (
		tick_run && !is_center && pr_eq && cfg_ff.channel_on_bit &&
		!(cfg_ff.offset_mode_field == pwo_pkg::OM_CONT && peer_rise) |=> channel_timer_ff == 16'h0000)
		else $error("timer did not restart after period");
	AST_TOGGLE: assert property (
		tick_run && cfg_ff.waveform_mode_field == pwo_pkg::WM_TOGGLE && ph_eq &&
		cfg_ff.channel_on_bit |=> out_ff != $past(out_ff))
		else $error("toggle mode did not invert");
	AST_CENTER_TURN: assert property (
		tick_run && is_center && dir_up_ff && pr_eq && cfg_ff.channel_on_bit &&
		cfg_ff.offset_mode_field != pwo_pkg::OM_CONT |=> !dir_up_ff && pr_eq)
		else $error("center mode did not turn at period");
	AST_OFF_HOLD: assert property (
		ce && !cfg_ff.channel_on_bit |=> channel_timer_ff == 16'h0000 && !out_ff)
		else $error("disabled channel not held idle");
	AST_FLAG_SET: assert property (
		s_hit_rise(0) or s_hit_rise(1) or s_hit_rise(2) or s_hit_rise(3) |=>
		(flags_ff & $past(hits & ~hit_prev_ff)) == $past(hits & ~hit_prev_ff))
		else $error("match flag not set on rising edge");
	AST_RELOAD: assert property (
		do_load && !arm_set |=> act_ff == $past(buf_ff) && !load_arm_bit_ff)
		else $error("reload did not copy buffers or clear arm");
	AST_ONESHOT_STOP: assert property (
		tick_run && !is_center && pr_eq && cfg_ff.channel_on_bit &&
		cfg_ff.offset_mode_field == pwo_pkg::OM_ONESHOT |=> state_ff == pwo_pkg::ST_DONE)
		else $error("one-shot timer did not stop at period");
	AST_CONT_RESET: assert property (
		running && peer_rise && cfg_ff.channel_on_bit &&
		cfg_ff.offset_mode_field == pwo_pkg::OM_CONT |=> channel_timer_ff == 16'h0001)
		else $error("continuous mode did not reset timer to one");
	AST_LEVEL_LAG: assert property (
		ce ##1 ce ##1 ce |-> pin_level_bit_ff == $past(out_ff, 2))
		else $error("level readback not two cycles behind output");
endmodule

// [pkg/pwo_pkg.sv]
// Shared constants and carriers for the offset-sync PWM channel
package pwo_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLKCON = 8'h04;
	localparam logic [7:0] ADDR_OFSCON = 8'h08;
	localparam logic [7:0] ADDR_LOAD = 8'h0c;
	localparam logic [7:0] ADDR_PHASE = 8'h10;
	localparam logic [7:0] ADDR_DUTY = 8'h14;
	localparam logic [7:0] ADDR_PERIOD = 8'h18;
	localparam logic [7:0] ADDR_OFFSET = 8'h1c;
	localparam logic [7:0] ADDR_TIMER = 8'h20;
	localparam logic [7:0] ADDR_FLAGS = 8'h24;
	// Channel control register fields
	localparam int CTRL_ON_BIT = 7;
	localparam int CTRL_OE_BIT = 6;
	localparam int CTRL_LEVEL_BIT = 5;
	localparam int CTRL_INV_BIT = 4;
	localparam int CTRL_MODE_LSB = 2;
	// Clock control register fields
	localparam int CLK_PS_LSB = 4;
	localparam int CLK_CS_LSB = 0;
	// Offset control register fields
	localparam int OFS_MODE_LSB = 0;
	localparam int OFS_SRC_LSB = 2;
	localparam int OFS_DIR_BIT = 4;
	// Load register and flag register fields
	localparam int LOAD_ARM_BIT = 0;
	localparam int FLAG_PR_BIT = 0;
	localparam int FLAG_DC_BIT = 1;
	localparam int FLAG_PH_BIT = 2;
	localparam int FLAG_OF_BIT = 3;
	// Reset values
	localparam logic [15:0] VAL_RESET = 16'h0000;
	localparam logic [6:0] PRE_RESET = 7'h00;
	// Waveform modes
	typedef enum logic [1:0] {
		WM_STANDARD = 2'b00,
		WM_SET = 2'b01,
		WM_TOGGLE = 2'b10,
		WM_CENTER = 2'b11
	} pwo_wmode_t;
	// Offset modes
	typedef enum logic [1:0] {
		OM_INDEP = 2'b00,
		OM_SYNC = 2'b01,
		OM_ONESHOT = 2'b10,
		OM_CONT = 2'b11
	} pwo_omode_t;
	// Timer run states, Gray coded along off, wait, run, done
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b11,
		ST_DONE = 2'b10
	} pwo_state_t;
	// The four compare values, buffered or active
	typedef struct packed {
		logic [15:0] phase_value;
		logic [15:0] duty_cycle_value;
		logic [15:0] period_value;
		logic [15:0] offset_value;
	} pwo_vals_t;
	// Channel configuration bits
	typedef struct packed {
		logic channel_on_bit;
		logic oe;
		logic invert_level_bit;
		pwo_wmode_t waveform_mode_field;
		pwo_omode_t offset_mode_field;
		logic [1:0] sync_source_select;
		logic center_match_direction_bit;
		logic [2:0] prescale;
		logic [1:0] clock_source;
	} pwo_cfg_t;
endpackage

// [tb/pwo_peer_model.sv]
`timescale 1ns/1ps
// Stands in for the peer channels and the external channel clock sources
module pwo_peer_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fire,
	input wire logic [1:0] sel,
	output logic [3:0] peer_sync_trigger,
	output logic [1:0] clk_src_tick
);
	// Peer match levels and free-running source clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			peer_sync_trigger <= 4'h0;
			clk_src_tick <= 2'h0;
		end else begin
			// Only the selected peer line moves; the others stay idle low
			peer_sync_trigger <= fire ? (4'h1 << sel) : 4'h0;
			// Two-bit counter: bit 0 halves, bit 1 quarters the bus clock
			clk_src_tick <= {clk_src_tick[1] ^ clk_src_tick[0], ~clk_src_tick[0]};
		end
	end
endmodule

// [tb/sixteen_bit_pwm_with_offset_sync_tb_top.sv]
`timescale 1ns/1ps
module sixteen_bit_pwm_with_offset_sync_tb_top;
	logic hclk, hresetn, ce, hsel, hwrite, fire; // Bench-driven controls
	logic [1:0] htrans, sel; // Bus phase, peer choice
	logic [31:0] haddr, hwdata, hrdata, rd, seed; // Bus data and random state
	logic hreadyout, hresp, pwm_pin, pwm_pin_oe_n, offset_match; // Design outputs
	logic [1:0] clk_src_tick; // From the partner
	logic [3:0] peer_sync_trigger; // From the partner
	int miscompares, checks, cyc, ne, nh, no, ps; // Counters and measurements
	pwo_channel #(.NPEER(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.clk_src_tick(clk_src_tick), .peer_sync_trigger(peer_sync_trigger),
		.pwm_pin(pwm_pin), .pwm_pin_oe_n(pwm_pin_oe_n), .offset_match(offset_match));
	pwo_peer_model i_peer (.hclk(hclk), .hresetn(hresetn), .fire(fire), .sel(sel),
		.peer_sync_trigger(peer_sync_trigger), .clk_src_tick(clk_src_tick));
	// 200 MHz clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Xorshift step for the fixed-seed stimulus
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Verdict and end of run, reached from the main flow or the watchdog
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One comparison, counted
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	// Single AHB-Lite transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, {24'h0, a}, d);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// Count pin rising edges, pin high cycles and offset-match rising edges
	task automatic meas(input int n);
		logic pp, po;
		pp = pwm_pin;
		po = offset_match;
		ne = 0;
		nh = 0;
		no = 0;
		repeat (n) begin
			@(posedge hclk);
			if (pwm_pin === 1'b1 && pp === 1'b0) ne++;
			if (pwm_pin === 1'b1) nh++;
			if (offset_match === 1'b1 && po === 1'b0) no++;
			pp = pwm_pin;
			po = offset_match;
		end
	endtask
	// Disable, load buffered values through the arm bit, then enable
	task automatic setup(input logic [31:0] c, k, o, ph, dc, pr, ofs);
		wr(pwo_pkg::ADDR_CTRL, 32'h0);
		wr(pwo_pkg::ADDR_CLKCON, k);
		wr(pwo_pkg::ADDR_OFSCON, o);
		wr(pwo_pkg::ADDR_PHASE, ph);
		wr(pwo_pkg::ADDR_DUTY, dc);
		wr(pwo_pkg::ADDR_PERIOD, pr);
		wr(pwo_pkg::ADDR_OFFSET, ofs);
		wr(pwo_pkg::ADDR_LOAD, 32'h1);
		repeat (4) @(posedge hclk);
		wr(pwo_pkg::ADDR_CTRL, c);
		repeat (40) @(posedge hclk);
	endtask
	// Hold the selected peer line high for a few cycles
	task automatic pulse_peer();
		fire <= 1'b1;
		repeat (4) @(posedge hclk);
		fire <= 1'b0;
	endtask
	// Watchdog: a hang counts as a mismatch
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up();
		end
	end
	// Main sequence; expectations from period and duty arithmetic
	initial begin
		{hresetn, ce, hsel, hwrite, fire, htrans, sel, haddr, hwdata} = '0;
		seed = 32'h9fade048;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ce <= 1'b1;
		@(posedge hclk);
		chk("pin_oe_n", 32'h1, {31'h0, pwm_pin_oe_n});
		rdc("ctrl", {24'h0, pwo_pkg::ADDR_CTRL}, 32'h0);
		rdc("period", {24'h0, pwo_pkg::ADDR_PERIOD}, {16'h0, pwo_pkg::VAL_RESET});
		bus(1'b1, 32'h100, 32'hffff_ffff);
		rdc("unmapped", 32'h100, 32'h0);
		$display("test registers done");
		// Standard mode, random prescale: period (pr+1)*2^ps cycles
		seed = xs(seed);
		ps = seed % 3;
		setup(32'hc0, ps << 4, 0, 1, 3, 4, 2);
		meas(50 << ps);
		chk("std_edges", 10, ne);
		chk("std_high", 20 << ps, nh);
		chk("ofs_edges", 10, no);
		chk("pin_oe_n", 0, {31'h0, pwm_pin_oe_n});
		rdc("flags", {24'h0, pwo_pkg::ADDR_FLAGS}, 32'hf);
		$display("test standard done");
		// Inverted polarity: high time is the complement
		setup(32'hd0, 0, 0, 1, 3, 4, 2);
		meas(50);
		chk("inv_high", 30, nh);
		// Channel clock from source 01, one tick every two cycles
		setup(32'hc0, 1, 0, 1, 3, 4, 2);
		meas(100);
		chk("src_edges", 10, ne);
		$display("test polarity and source done");
		// Toggle mode; a level write made while already toggling must not reach the pin
		setup(32'he8, 0, 0, 1, 3, 4, 2);
		wr(pwo_pkg::ADDR_CTRL, 32'he8);
		meas(100);
		chk("tgl_edges", 10, ne);
		chk("tgl_high", 50, nh);
		// Clock enable low freezes the pin; one edge lets the last launched value settle
		ce <= 1'b0;
		@(posedge hclk);
		meas(20);
		chk("ce_freeze", 0, ne);
		ce <= 1'b1;
		// Center aligned: period 2*(pr+1) ticks
		setup(32'hcc, 0, 0, 1, 2, 4, 2);
		meas(100);
		chk("ctr_edges", 10, ne);
		$display("test toggle and center done");
		// Set on match: stays high until the level bit is cleared
		setup(32'hc4, 0, 0, 1, 3, 4, 2);
		meas(50);
		chk("set_high", 50, nh);
		// One idle cycle keeps the clear off a phase-match tick, where phase wins
		@(posedge hclk);
		wr(pwo_pkg::ADDR_CTRL, 32'hc4);
		meas(20);
		chk("set_clear", 1, ne);
		rdc("set_level", {24'h0, pwo_pkg::ADDR_CTRL}, 32'he4);
		// Disabled: inactive level inverted to high, timer held
		wr(pwo_pkg::ADDR_CTRL, 32'h50);
		repeat (4) @(posedge hclk);
		chk("off_pin", 1, {31'h0, pwm_pin});
		rdc("off_timer", {24'h0, pwo_pkg::ADDR_TIMER}, 32'h0);
		$display("test set and disable done");
		// Sync start on a random peer line
		seed = xs(seed);
		sel <= seed[1:0];
		setup(32'hc0, 0, 1 | (seed[1:0] << 2), 1, 3, 4, 2);
		meas(50);
		chk("sync_wait", 0, ne);
		pulse_peer();
		repeat (20) @(posedge hclk);
		meas(50);
		chk("sync_run", 10, ne);
		// One-shot: a single period per peer edge
		setup(32'hc0, 0, 2 | (seed[1:0] << 2), 1, 3, 4, 2);
		pulse_peer();
		meas(60);
		chk("shot_one", 1, ne);
		pulse_peer();
		meas(60);
		chk("shot_two", 1, ne);
		// Continuous: start on a peer edge, a later edge restarts the count at one
		setup(32'hc0, 0, 3 | (seed[1:0] << 2), 1, 3, 4, 2);
		pulse_peer();
		meas(50);
		chk("cont_run", 10, ne);
		pulse_peer();
		meas(50);
		chk("cont_again", 10, ne);
		$display("test offset modes done");
		wrap_up();
	end
endmodule
